// ### hw/pmimb_top.sv
// Function
// - global mask bit 7 gates power-good interrupt
// - power-good mask leaves power-good status alone
// - global mask bit 4 gates clock interrupt
// - global mask bit 2 gates thermal warning
// - thermal mask leaves thermal status alone
// - global mask bit 0 gates measurement-ready interrupt
// - global bits 6:5,3,1 reserved, writable, reset zero
// - reset mask bit 0 gates register-reset interrupt
// - reset mask bit loaded from OTP only
// - buck bit 7 masks second invalid detection
// - buck bit 6 masks second valid detection
// - buck bit 4 gates second current limit
// - buck bit 3 masks first invalid detection
// - buck bit 2 masks first valid detection
// - buck bit 0 gates first current limit
// - buck bits 5,1 read zero, ignore writes
// - buck masks leave raw statuses alone
// - raw pg is 1 when invalid
`timescale 1ns/100ps
`default_nettype none
`include "pmimb_defines.svh"

module pmimb_top (
    input wire logic CLK_I,
    input wire logic RESET_N_I,
    input wire logic PG_PIN_I,
    input wire logic CLK_INVALID_I,
    input wire logic THERMAL_WARN_I,
    input wire logic SECOND_BUCK_PG_INVALID_I,
    input wire logic SECOND_BUCK_LIMIT_I,
    input wire logic FIRST_BUCK_PG_INVALID_I,
    input wire logic FIRST_BUCK_LIMIT_I,
    input wire logic MEAS_READY_I,
    input wire logic REG_RESET_EVENT_I,
    input wire logic OTP_RESET_MASK_I,
    input wire logic [7:0] REG_ADDR_I,
    input wire logic [7:0] REG_WDATA_I,
    input wire logic REG_WR_I,
    input wire logic REG_RD_I,
    output logic [7:0] REG_RDATA_O,
    output logic INT_O
);
    // ****************************************************************
    // reset release
    // ****************************************************************
    logic [1:0] rsync_q;
    logic rst_n;

    // two flip-flops release the asynchronous reset synchronously
    always_ff @(posedge CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            rsync_q <= 2'h0;
        end else begin
            rsync_q <= {rsync_q[0], 1'b1};
        end
    end
    assign rst_n = rsync_q[1];

    // ****************************************************************
    // pin synchronisers
    // ****************************************************************
    pmimb_sync_if sync_bus ();
    logic [`PMIMB_PIN_N-1:0] pins;

    // gather the asynchronous condition pins
    always_comb begin
        pins = '0;
        pins[`PMIMB_P_PG] = PG_PIN_I;
        pins[`PMIMB_P_CLK] = CLK_INVALID_I;
        pins[`PMIMB_P_TW] = THERMAL_WARN_I;
        pins[`PMIMB_P_B1PG] = SECOND_BUCK_PG_INVALID_I;
        pins[`PMIMB_P_B1IL] = SECOND_BUCK_LIMIT_I;
        pins[`PMIMB_P_B0PG] = FIRST_BUCK_PG_INVALID_I;
        pins[`PMIMB_P_B0IL] = FIRST_BUCK_LIMIT_I;
    end

    pmimb_sync u_sync (
        .clk_i(CLK_I),
        .rst_n_i(rst_n),
        .pin_i(pins),
        .sync_o(sync_bus.src)
    );

    // ****************************************************************
    // mask bank state
    // ****************************************************************
    pmimb_pkg::pmimb_state_t q;
    pmimb_pkg::pmimb_state_t d;
    logic [7:0] set_t;
    logic [7:0] set_b;
    logic [7:0] clr_t;
    logic [7:0] clr_b;
    logic [7:0] top_stat;
    logic [7:0] buck_stat;

    // live status views, never touched by the masks
    always_comb begin
        top_stat = 8'h00;
        top_stat[`PMIMB_B_PG] = sync_bus.lvl[`PMIMB_P_PG];
        top_stat[`PMIMB_B_CLK] = sync_bus.lvl[`PMIMB_P_CLK];
        top_stat[`PMIMB_B_TW] = sync_bus.lvl[`PMIMB_P_TW];
        buck_stat = 8'h00;
        buck_stat[`PMIMB_B_B1PG] = sync_bus.lvl[`PMIMB_P_B1PG];
        buck_stat[`PMIMB_B_B1IL] = sync_bus.lvl[`PMIMB_P_B1IL];
        buck_stat[`PMIMB_B_B0PG] = sync_bus.lvl[`PMIMB_P_B0PG];
        buck_stat[`PMIMB_B_B0IL] = sync_bus.lvl[`PMIMB_P_B0IL];
    end

    // event detection gated by the mask bits
    always_comb begin
        set_t = 8'h00;
        set_t[`PMIMB_B_PG] = (sync_bus.rise[`PMIMB_P_PG] | sync_bus.fall[`PMIMB_P_PG])
            & ~q.glb[`PMIMB_B_PG];
        set_t[`PMIMB_B_CLK] = sync_bus.rise[`PMIMB_P_CLK] & ~q.glb[`PMIMB_B_CLK];
        set_t[`PMIMB_B_TW] = sync_bus.rise[`PMIMB_P_TW] & ~q.glb[`PMIMB_B_TW];
        set_t[`PMIMB_B_MEAS] = MEAS_READY_I & ~q.glb[`PMIMB_B_MEAS];
        set_t[`PMIMB_B_REGRST_FLG] = REG_RESET_EVENT_I & ~q.rst[`PMIMB_B_REGRST];
        set_b = 8'h00;
        set_b[`PMIMB_B_B1PG] = (sync_bus.rise[`PMIMB_P_B1PG] & ~q.buck[`PMIMB_B_B1PGF])
            | (sync_bus.fall[`PMIMB_P_B1PG] & ~q.buck[`PMIMB_B_B1PGR]);
        set_b[`PMIMB_B_B1IL] = sync_bus.rise[`PMIMB_P_B1IL] & ~q.buck[`PMIMB_B_B1IL];
        set_b[`PMIMB_B_B0PG] = (sync_bus.rise[`PMIMB_P_B0PG] & ~q.buck[`PMIMB_B_B0PGF])
            | (sync_bus.fall[`PMIMB_P_B0PG] & ~q.buck[`PMIMB_B_B0PGR]);
        set_b[`PMIMB_B_B0IL] = sync_bus.rise[`PMIMB_P_B0IL] & ~q.buck[`PMIMB_B_B0IL];
    end

    // register writes, flag update and read capture
    always_comb begin
        d = q;
        clr_t = 8'h00;
        clr_b = 8'h00;
        if (REG_WR_I) begin
            case (REG_ADDR_I)
                `PMIMB_OFS_GLB_MASK: begin
                    d.glb = REG_WDATA_I;
                end
                `PMIMB_OFS_RST_MASK: begin
                    d.rst = {REG_WDATA_I[7:1], q.rst[`PMIMB_B_REGRST]};
                end
                `PMIMB_OFS_BUCK_MASK: begin
                    d.buck = REG_WDATA_I & `PMIMB_WR_BUCK_MASK;
                end
                `PMIMB_OFS_TOP_FLAG: begin
                    clr_t = REG_WDATA_I;
                end
                `PMIMB_OFS_BUCK_FLAG: begin
                    clr_b = REG_WDATA_I;
                end
                default: begin
                    d.glb = q.glb;
                end
            endcase
        end
        // first edge after release takes the stored mask value
        if (!q.loaded) begin
            d.rst[`PMIMB_B_REGRST] = OTP_RESET_MASK_I;
            d.loaded = 1'b1;
        end
        // a set in the clearing cycle wins over the clear
        d.tflg = (q.tflg & ~clr_t) | set_t;
        d.bflg = (q.bflg & ~clr_b) | set_b;
        d.irq = |{d.tflg, d.bflg};
        if (REG_RD_I) begin
            case (REG_ADDR_I)
                `PMIMB_OFS_GLB_MASK: d.rdata = q.glb;
                `PMIMB_OFS_RST_MASK: d.rdata = q.rst;
                `PMIMB_OFS_BUCK_MASK: d.rdata = q.buck;
                `PMIMB_OFS_TOP_FLAG: d.rdata = q.tflg;
                `PMIMB_OFS_BUCK_FLAG: d.rdata = q.bflg;
                `PMIMB_OFS_TOP_STAT: d.rdata = top_stat;
                `PMIMB_OFS_BUCK_STAT: d.rdata = buck_stat;
                default: d.rdata = 8'h00;
            endcase
        end
    end

    // state register with documented defaults
    always_ff @(posedge CLK_I or negedge rst_n) begin
        if (!rst_n) begin
            q.glb <= `PMIMB_RST_GLB_MASK;
            q.rst <= `PMIMB_RST_RST_MASK;
            q.buck <= `PMIMB_RST_BUCK_MASK;
            q.tflg <= `PMIMB_RST_ZERO;
            q.bflg <= `PMIMB_RST_ZERO;
            q.rdata <= `PMIMB_RST_ZERO;
            q.loaded <= 1'b0;
            q.irq <= 1'b0;
        end else begin
            q <= d;
        end
    end

    assign REG_RDATA_O = q.rdata;
    assign INT_O = q.irq;

    // ****************************************************************
    // assertions
    // ****************************************************************
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (!rst_n);

    property p_pg_unmasked;
        (sync_bus.rise[`PMIMB_P_PG] || sync_bus.fall[`PMIMB_P_PG]) && !q.glb[`PMIMB_B_PG]
            |=> q.tflg[`PMIMB_B_PG];
    endproperty
    a_pg_unmasked: assert property (p_pg_unmasked) else $error("pg event lost");

    property p_top_stat;
        REG_RD_I && REG_ADDR_I == `PMIMB_OFS_TOP_STAT |=> REG_RDATA_O == $past(top_stat)
            && REG_RDATA_O[`PMIMB_B_PG] == $past(sync_bus.lvl[`PMIMB_P_PG]);
    endproperty
    a_top_stat: assert property (p_top_stat) else $error("top status wrong");

    property p_clk_cause;
        $rose(q.tflg[`PMIMB_B_CLK]) |-> $past(sync_bus.rise[`PMIMB_P_CLK])
            && !$past(q.glb[`PMIMB_B_CLK]);
    endproperty
    a_clk_cause: assert property (p_clk_cause) else $error("clock flag without cause");

    property p_tw_masked;
        q.glb[`PMIMB_B_TW] && !q.tflg[`PMIMB_B_TW] throughout (##1 1'b1) |=> !q.tflg[`PMIMB_B_TW];
    endproperty
    a_tw_masked: assert property (p_tw_masked) else $error("masked thermal flag set");

    property p_meas;
        MEAS_READY_I |=> q.tflg[`PMIMB_B_MEAS] == ($past(q.tflg[`PMIMB_B_MEAS])
            || !$past(q.glb[`PMIMB_B_MEAS]));
    endproperty
    a_meas: assert property (p_meas) else $error("measure flag wrong");

    property p_glb_write;
        REG_WR_I && REG_ADDR_I == `PMIMB_OFS_GLB_MASK |=> q.glb == $past(REG_WDATA_I);
    endproperty
    a_glb_write: assert property (p_glb_write) else $error("global mask not stored");

    property p_rst_write;
        REG_WR_I && REG_ADDR_I == `PMIMB_OFS_RST_MASK && q.loaded
            |=> q.rst == {$past(REG_WDATA_I[7:1]), $past(q.rst[`PMIMB_B_REGRST])};
    endproperty
    a_rst_write: assert property (p_rst_write) else $error("reset mask write wrong");

    property p_otp_load;
        !q.loaded |=> q.loaded && q.rst[`PMIMB_B_REGRST] == $past(OTP_RESET_MASK_I);
    endproperty
    a_otp_load: assert property (p_otp_load) else $error("otp mask not loaded");

    property p_b1pg_cause;
        $rose(q.bflg[`PMIMB_B_B1PG]) |-> $past(
            (sync_bus.rise[`PMIMB_P_B1PG] && !q.buck[`PMIMB_B_B1PGF])
            || (sync_bus.fall[`PMIMB_P_B1PG] && !q.buck[`PMIMB_B_B1PGR]));
    endproperty
    a_b1pg_cause: assert property (p_b1pg_cause) else $error("second pg flag without cause");

    property p_b0pg_set;
        (sync_bus.rise[`PMIMB_P_B0PG] && !q.buck[`PMIMB_B_B0PGF])
            || (sync_bus.fall[`PMIMB_P_B0PG] && !q.buck[`PMIMB_B_B0PGR]) |=> q.bflg[`PMIMB_B_B0PG];
    endproperty
    a_b0pg_set: assert property (p_b0pg_set) else $error("first pg event lost");

    property p_ilim;
        sync_bus.rise[`PMIMB_P_B0IL] && !q.buck[`PMIMB_B_B0IL] |=> q.bflg[`PMIMB_B_B0IL];
    endproperty
    a_ilim: assert property (p_ilim) else $error("first limit event lost");

    property p_ilim_second;
        sync_bus.rise[`PMIMB_P_B1IL] && !q.buck[`PMIMB_B_B1IL] |=> q.bflg[`PMIMB_B_B1IL];
    endproperty
    a_ilim_second: assert property (p_ilim_second) else $error("second limit event lost");

    property p_buck_rsvd;
        q.buck[5] == 1'b0 && q.buck[1] == 1'b0;
    endproperty
    a_buck_rsvd: assert property (p_buck_rsvd) else $error("reserved buck bit set");

    property p_buck_stat;
        REG_RD_I && REG_ADDR_I == `PMIMB_OFS_BUCK_STAT |=> REG_RDATA_O[`PMIMB_B_B1PG]
            == $past(sync_bus.lvl[`PMIMB_P_B1PG]) && REG_RDATA_O[`PMIMB_B_B0IL]
            == $past(sync_bus.lvl[`PMIMB_P_B0IL]);
    endproperty
    a_buck_stat: assert property (p_buck_stat) else $error("buck status wrong");

    property p_irq;
        INT_O == (|q.tflg || |q.bflg);
    endproperty
    a_irq: assert property (p_irq) else $error("interrupt out of step");

    property p_pg_masked;
        q.glb[`PMIMB_B_PG] && !q.tflg[`PMIMB_B_PG] |=> !q.tflg[`PMIMB_B_PG];
    endproperty
    a_pg_masked: assert property (p_pg_masked) else $error("masked pg flag set");

    property p_clk_masked;
        q.glb[`PMIMB_B_CLK] && !q.tflg[`PMIMB_B_CLK] |=> !q.tflg[`PMIMB_B_CLK];
    endproperty
    a_clk_masked: assert property (p_clk_masked) else $error("masked clock flag set");

    property p_tw_set;
        sync_bus.rise[`PMIMB_P_TW] && !q.glb[`PMIMB_B_TW] |=> q.tflg[`PMIMB_B_TW];
    endproperty
    a_tw_set: assert property (p_tw_set) else $error("thermal event lost");

    property p_regrst;
        REG_RESET_EVENT_I && !q.rst[`PMIMB_B_REGRST] |=> q.tflg[`PMIMB_B_REGRST_FLG];
    endproperty
    a_regrst: assert property (p_regrst) else $error("register reset event lost");

    property p_buck_write;
        REG_WR_I && REG_ADDR_I == `PMIMB_OFS_BUCK_MASK |=> q.buck == ($past(REG_WDATA_I) & `PMIMB_WR_BUCK_MASK);
    endproperty
    a_buck_write: assert property (p_buck_write) else $error("buck mask write wrong");

    property p_b1pg_masked;
        q.buck[`PMIMB_B_B1PGF] && q.buck[`PMIMB_B_B1PGR] && !q.bflg[`PMIMB_B_B1PG] |=> !q.bflg[`PMIMB_B_B1PG];
    endproperty
    a_b1pg_masked: assert property (p_b1pg_masked) else $error("masked second pg flag set");

    property p_flag_clear;
        REG_WR_I && REG_ADDR_I == `PMIMB_OFS_TOP_FLAG
            |=> q.tflg == (($past(q.tflg) & ~$past(REG_WDATA_I)) | $past(set_t));
    endproperty
    a_flag_clear: assert property (p_flag_clear) else $error("top flag clear wrong");

    property p_set_wins;
        |set_b |=> (q.bflg & $past(set_b)) == $past(set_b);
    endproperty
    a_set_wins: assert property (p_set_wins) else $error("buck flag set lost");

    property p_rdata_hold;
        !REG_RD_I |=> $stable(REG_RDATA_O);
    endproperty
    a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved without read");

    // ****************************************************************
    // cover points
    // ****************************************************************
    c_pg_irq: cover property (set_t[`PMIMB_B_PG] ##1 INT_O);
    c_b1_valid: cover property (sync_bus.fall[`PMIMB_P_B1PG] && !q.buck[`PMIMB_B_B1PGR]);
    c_set_clear: cover property (REG_WR_I && REG_ADDR_I == `PMIMB_OFS_BUCK_FLAG && |set_b);
    c_otp_masked: cover property (REG_RESET_EVENT_I && q.rst[`PMIMB_B_REGRST]);
    c_meas_irq: cover property (set_t[`PMIMB_B_MEAS] ##1 INT_O);
endmodule : pmimb_top

`default_nettype wire

// ### hw/pmimb_defines.svh
`ifndef PMIMB_DEFINES_SVH
`define PMIMB_DEFINES_SVH

// ****************************************************************
// register offsets
// ****************************************************************
`define PMIMB_OFS_TOP_FLAG 8'h18
`define PMIMB_OFS_BUCK_FLAG 8'h19
`define PMIMB_OFS_TOP_STAT 8'h1D
`define PMIMB_OFS_BUCK_STAT 8'h1E
`define PMIMB_OFS_GLB_MASK 8'h20
`define PMIMB_OFS_RST_MASK 8'h21
`define PMIMB_OFS_BUCK_MASK 8'h22

// ****************************************************************
// reset values and writable bits
// ****************************************************************
`define PMIMB_RST_GLB_MASK 8'h90
`define PMIMB_RST_RST_MASK 8'h01
`define PMIMB_RST_BUCK_MASK 8'hCC
`define PMIMB_WR_BUCK_MASK 8'hDD
`define PMIMB_RST_ZERO 8'h00

// ****************************************************************
// field positions (mask, flag and status share positions, except the buck pg masks 7/6 and 3/2 and the reset mask bit 0 vs flag bit 1)
// ****************************************************************
`define PMIMB_B_PG 7
`define PMIMB_B_CLK 4
`define PMIMB_B_TW 2
`define PMIMB_B_MEAS 0
`define PMIMB_B_REGRST_FLG 1
`define PMIMB_B_REGRST 0
`define PMIMB_B_B1PGF 7
`define PMIMB_B_B1PGR 6
`define PMIMB_B_B1PG 6
`define PMIMB_B_B1IL 4
`define PMIMB_B_B0PGF 3
`define PMIMB_B_B0PGR 2
`define PMIMB_B_B0PG 2
`define PMIMB_B_B0IL 0

// ****************************************************************
// pin input indices
// ****************************************************************
`define PMIMB_PIN_N 7
`define PMIMB_P_PG 0
`define PMIMB_P_CLK 1
`define PMIMB_P_TW 2
`define PMIMB_P_B1PG 3
`define PMIMB_P_B1IL 4
`define PMIMB_P_B0PG 5
`define PMIMB_P_B0IL 6

`endif

// ### hw/pmimb_pkg.sv
`default_nettype none
`include "pmimb_defines.svh"

package pmimb_pkg;
    // ****************************************************************
    // state of the pin synchroniser
    // ****************************************************************
    typedef struct packed {
        logic [`PMIMB_PIN_N-1:0] s1;
        logic [`PMIMB_PIN_N-1:0] s2;
        logic [`PMIMB_PIN_N-1:0] s3;
        logic [`PMIMB_PIN_N-1:0] lvl;
        logic [`PMIMB_PIN_N-1:0] rise;
        logic [`PMIMB_PIN_N-1:0] fall;
    } pmimb_sync_st_t;

    // ****************************************************************
    // state of the mask bank
    // ****************************************************************
    typedef struct packed {
        logic [7:0] glb;
        logic [7:0] rst;
        logic [7:0] buck;
        logic [7:0] tflg;
        logic [7:0] bflg;
        logic [7:0] rdata;
        logic loaded;
        logic irq;
    } pmimb_state_t;
endpackage : pmimb_pkg

`default_nettype wire

// ### hw/pmimb_sync_if.sv
`timescale 1ns/100ps
`default_nettype none
`include "pmimb_defines.svh"

// filtered pin levels and their one-cycle edge pulses
interface pmimb_sync_if;
    logic [`PMIMB_PIN_N-1:0] lvl;
    logic [`PMIMB_PIN_N-1:0] rise;
    logic [`PMIMB_PIN_N-1:0] fall;
    modport src (output lvl, output rise, output fall);
    modport dst (input lvl, input rise, input fall);
endinterface : pmimb_sync_if

`default_nettype wire

// ### hw/pmimb_sync.sv
`timescale 1ns/100ps
`default_nettype none
`include "pmimb_defines.svh"

module pmimb_sync (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic [`PMIMB_PIN_N-1:0] pin_i,
    pmimb_sync_if.src sync_o
);
    pmimb_pkg::pmimb_sync_st_t q;
    pmimb_pkg::pmimb_sync_st_t d;
    logic [`PMIMB_PIN_N-1:0] agree;

    // ****************************************************************
    // three stages; a change counts once stages two and three agree
    // ****************************************************************
    always_comb begin
        d = q;
        d.s1 = pin_i;
        d.s2 = q.s1;
        d.s3 = q.s2;
        agree = ~(q.s2 ^ q.s3);
        d.lvl = (q.lvl & ~agree) | (q.s3 & agree);
        d.rise = d.lvl & ~q.lvl;
        d.fall = ~d.lvl & q.lvl;
    end

    // state register
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    // outputs come straight from the state
    assign sync_o.lvl = q.lvl;
    assign sync_o.rise = q.rise;
    assign sync_o.fall = q.fall;
endmodule : pmimb_sync

`default_nettype wire

// ### verification/pmimb_host_model.sv
`timescale 1ns/100ps
`default_nettype none

// ****************************************************************
// host side of the register strobe port
// ****************************************************************
module pmimb_host_model (
    input wire logic clk_i,
    input wire logic [7:0] rdata_i,
    output var logic [7:0] addr_o,
    output var logic [7:0] wdata_o,
    output var logic wr_o,
    output var logic rd_o
);
    // idle port from time zero
    initial begin
        addr_o = 8'h00;
        wdata_o = 8'h00;
        wr_o = 1'b0;
        rd_o = 1'b0;
    end

    // one-cycle write strobe, taken at the following edge
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_i);
        addr_o <= a;
        wdata_o <= d;
        wr_o <= 1'b1;
        @(posedge clk_i);
        wr_o <= 1'b0;
    endtask : wr_reg

    // one-cycle read strobe, data sampled once it has settled
    task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk_i);
        addr_o <= a;
        rd_o <= 1'b1;
        @(posedge clk_i);
        rd_o <= 1'b0;
        @(posedge clk_i);
        #1;
        d = rdata_i;
    endtask : rd_reg
endmodule : pmimb_host_model

`default_nettype wire

// ### verification/tb_top.sv
`timescale 1ns/100ps
`default_nettype none
`include "pmimb_defines.svh"

module tb_top;
    localparam logic [7:0] glb_a = `PMIMB_OFS_GLB_MASK;
    localparam logic [7:0] rst_a = `PMIMB_OFS_RST_MASK;
    localparam logic [7:0] bck_a = `PMIMB_OFS_BUCK_MASK;
    localparam logic [7:0] tf_a = `PMIMB_OFS_TOP_FLAG;
    localparam logic [7:0] bf_a = `PMIMB_OFS_BUCK_FLAG;
    logic clk, reset_n, otp_mask, reg_wr, reg_rd, irq;
    logic [8:0] ev;
    logic [7:0] addr, wdata, rdata;
    int mismatches;
    int checks_done;

    // ****************************************************************
    // design and host
    // ****************************************************************
    pmimb_top i_pmimb_top (.CLK_I(clk), .RESET_N_I(reset_n), .PG_PIN_I(ev[0]), .CLK_INVALID_I(ev[1]),
        .THERMAL_WARN_I(ev[2]), .SECOND_BUCK_PG_INVALID_I(ev[3]), .SECOND_BUCK_LIMIT_I(ev[4]),
        .FIRST_BUCK_PG_INVALID_I(ev[5]), .FIRST_BUCK_LIMIT_I(ev[6]), .MEAS_READY_I(ev[7]),
        .REG_RESET_EVENT_I(ev[8]), .OTP_RESET_MASK_I(otp_mask), .REG_ADDR_I(addr), .REG_WDATA_I(wdata),
        .REG_WR_I(reg_wr), .REG_RD_I(reg_rd), .REG_RDATA_O(rdata), .INT_O(irq));
    pmimb_host_model i_pmimb_host_model (.clk_i(clk), .rdata_i(rdata), .addr_o(addr), .wdata_o(wdata),
        .wr_o(reg_wr), .rd_o(reg_rd));

    // free-running 10 MHz clock
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    // ****************************************************************
    // shared tasks
    // ****************************************************************
    task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp_v);
        checks_done++;
        if (seen !== exp_v) begin
            mismatches++;
            $display("Error %s expected %h seen %h", name, exp_v, seen);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        i_pmimb_host_model.wr_reg(a, d);
    endtask : wr

    task automatic rdchk(input string name, input logic [7:0] a, input logic [7:0] exp_v);
        logic [7:0] d;
        i_pmimb_host_model.rd_reg(a, d);
        chk(name, d, exp_v);
    endtask : rdchk

    // pins are levels, the two top indices are one-cycle pulses
    task automatic drive(input int idx, input logic lvl);
        @(posedge clk);
        ev[idx] <= lvl;
        if (idx >= 7) begin
            @(posedge clk);
            ev[idx] <= 1'b0;
        end
        repeat (8) @(posedge clk);
    endtask : drive

    task automatic clear_flags();
        wr(tf_a, 8'hFF);
        wr(bf_a, 8'hFF);
        repeat (2) @(posedge clk);
    endtask : clear_flags

    // one event masked, then unmasked alone; only the second sets its flag
    task automatic gate(input logic [7:0] mreg, input int mbit, input logic [7:0] freg, input int fbit,
        input int idx, input logic lvl);
        logic [7:0] m;
        for (int u = 0; u < 2; u++) begin
            m = (u == 0) ? 8'hFF : ~(8'h01 << mbit);
            wr(mreg, m);
            drive(idx, ~lvl);
            clear_flags();
            drive(idx, lvl);
            rdchk("flag", freg, (u == 0) ? 8'h00 : (8'h01 << fbit));
            chk("irq", {7'h00, irq}, {7'h00, u == 1});
        end
        clear_flags();
    endtask : gate

    // ****************************************************************
    // scenarios
    // ****************************************************************
    task automatic t_reset_values();
        rdchk("glb_mask", glb_a, 8'h90);
        rdchk("rst_mask", rst_a, 8'h00);
        rdchk("buck_mask", bck_a, 8'hCC);
        rdchk("unmapped", 8'h3F, 8'h00);
        chk("irq_idle", {7'h00, irq}, 8'h00);
    endtask : t_reset_values

    task automatic t_reserved();
        wr(rst_a, 8'h01);
        rdchk("rst_mask_bit0", rst_a, 8'h00);
        wr(rst_a, 8'hFF);
        rdchk("rst_mask_rsvd", rst_a, 8'hFE);
        wr(rst_a, 8'h00);
        wr(glb_a, 8'h6A);
        rdchk("glb_rsvd", glb_a, 8'h6A);
        wr(bck_a, 8'hFF);
        rdchk("buck_rsvd_set", bck_a, 8'hDD);
        wr(bck_a, 8'h22);
        rdchk("buck_rsvd_only", bck_a, 8'h00);
    endtask : t_reserved

    // raw statuses read the same under full and no masking
    task automatic t_status();
        for (int u = 0; u < 2; u++) begin
            wr(glb_a, (u == 0) ? 8'hFF : 8'h00);
            wr(bck_a, (u == 0) ? 8'hFF : 8'h00);
            @(posedge clk);
            ev <= 9'h04F;
            repeat (8) @(posedge clk);
            rdchk("top_status", `PMIMB_OFS_TOP_STAT, 8'h94);
            rdchk("buck_status", `PMIMB_OFS_BUCK_STAT, 8'h41);
            ev <= 9'h000;
            repeat (8) @(posedge clk);
            rdchk("buck_status_low", `PMIMB_OFS_BUCK_STAT, 8'h00);
            clear_flags();
        end
    endtask : t_status

    task automatic t_gates();
        gate(glb_a, 7, tf_a, 7, 0, 1'b1);
        gate(glb_a, 7, tf_a, 7, 0, 1'b0);
        gate(glb_a, 4, tf_a, 4, 1, 1'b1);
        gate(glb_a, 2, tf_a, 2, 2, 1'b1);
        gate(glb_a, 0, tf_a, 0, 7, 1'b1);
        gate(bck_a, 7, bf_a, 6, 3, 1'b1);
        gate(bck_a, 6, bf_a, 6, 3, 1'b0);
        gate(bck_a, 4, bf_a, 4, 4, 1'b1);
        gate(bck_a, 3, bf_a, 2, 5, 1'b1);
        gate(bck_a, 2, bf_a, 2, 5, 1'b0);
        gate(bck_a, 0, bf_a, 0, 6, 1'b1);
    endtask : t_gates

    // reset-mask bit came from the OTP level, zero here, so the event flags
    task automatic t_regrst();
        clear_flags();
        drive(8, 1'b1);
        rdchk("regrst_flag", tf_a, 8'h02);
        chk("regrst_irq", {7'h00, irq}, 8'h01);
        clear_flags();
        chk("irq_cleared", {7'h00, irq}, 8'h00);
    endtask : t_regrst

    // second reset with the stored mask at one: the bit comes back set and ignores writes
    task automatic t_otp_reset();
        @(posedge clk);
        reset_n <= 1'b0;
        otp_mask <= 1'b1;
        ev <= 9'h000;
        repeat (6) @(posedge clk);
        reset_n <= 1'b1;
        repeat (5) @(posedge clk);
        rdchk("glb_after_reset", glb_a, 8'h90);
        rdchk("rst_mask_otp", rst_a, 8'h01);
        wr(rst_a, 8'h00);
        rdchk("rst_mask_kept", rst_a, 8'h01);
        drive(8, 1'b1);
        rdchk("regrst_masked", tf_a, 8'h00);
        chk("regrst_masked_irq", {7'h00, irq}, 8'h00);
    endtask : t_otp_reset

    // ****************************************************************
    // run control
    // ****************************************************************
    task automatic wrap_up();
        $display("mismatches %0d checks %0d", mismatches, checks_done);
        if (mismatches == 0 && checks_done > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : wrap_up

    // main sequence
    initial begin
        mismatches = 0;
        checks_done = 0;
        reset_n = 1'b0;
        otp_mask = 1'b0;
        ev = 9'h000;
        repeat (6) @(posedge clk);
        reset_n <= 1'b1;
        repeat (5) @(posedge clk);
        t_reset_values();
        t_reserved();
        t_status();
        t_gates();
        t_regrst();
        t_otp_reset();
        wrap_up();
    end

    // watchdog, about twenty times the expected run
    initial begin
        #2000000;
        mismatches++;
        wrap_up();
    end
endmodule : tb_top

`default_nettype wire
